// ===== common/guard_map.vh
// Constants for the transient and over-current guard block
`ifndef GUARD_MAP_VH
`define GUARD_MAP_VH
// AXI4-Lite register byte offsets
`define REG_CTRL        4'h0
`define REG_STATUS      4'h4
`define REG_STRAP       4'h8
`define REG_QR_CFG      4'hC
// Control field positions
`define CTRL_CLEAR_BIT  0
`define CTRL_QR_EN_BIT  1
`define CTRL_RST_VAL    32'h0000_0002
// Strap band decode: band of 100 mV steps, 16 bands from 75 mV
`define STRAP_BAND_W    4
// Quick-response settings for the 35 mV / 1.3 x band (band 12)
`define QR_BAND_35MV    4'hC
`define QUICK_RESPONSE_THRESHOLD_35MV      8'd35
`define QUICK_RESPONSE_WIDTH_X10    8'd13
// Step threshold codes in mV (0 = disabled)
`define STEP_TH_15      8'd15
`define STEP_TH_30      8'd30
`define STEP_TH_60      8'd60
`define STEP_TH_OFF     8'd0
// Summed trip scale: 160 percent of the 0.4 V monitor point
`define SUM_OC_PCT      8'd160
`define SUM_OC_BASE     8'd100
// Clock rate and times
`define CLK_MHZ         40
`define SUM_DELAY_US    40
`define SUM_MASK_US     80
`define SPIKE_DELAY_US  1
`define STEP_WIN_US     2
`define SUM_DELAY_CYC   (`SUM_DELAY_US * `CLK_MHZ)
`define SUM_MASK_CYC    (`SUM_MASK_US * `CLK_MHZ)
`define SPIKE_DELAY_CYC (`SPIKE_DELAY_US * `CLK_MHZ)
`define STEP_WIN_CYC    (`STEP_WIN_US * `CLK_MHZ)
`endif

// ===== core/hold_timer.v
// Continuous-condition delay timer with an expiry flag held while the condition lasts
`timescale 1ns/1ps
module hold_timer #(
  parameter WIDTH = 12
) (
  // Clock and reset
  input  wire             i_core_clk,
  input  wire             i_sys_rst,
  // Condition and length
  input  wire             i_cond,
  input  wire [WIDTH-1:0] i_len,
  // Result
  output reg              o_done
);
  reg [WIDTH-1:0] count;

  // Counts while the condition holds; any gap restarts the count
  always @(posedge i_core_clk) begin
    if (i_sys_rst || !i_cond) begin
      count  <= {WIDTH{1'b0}};
      o_done <= 1'b0;
    end else if (count + 1'b1 >= i_len) begin
      o_done <= 1'b1;
    end else begin
      count  <= count + 1'b1;
      o_done <= 1'b0;
    end
  end
endmodule // hold_timer

// ===== core/transient_and_overcurrent_guard.v
// Quick response, overshoot guard, over-current trips and strap decode
`timescale 1ns/1ps
`include "guard_map.vh"
// What this block does
// - On a large load step, pulse all high gates once together.
// - Trigger comes from output sense drop compared with the set threshold.
// - Each event uses a threshold and a width in on-time multiples.
// - Threshold comes from pin a and width from pin b (pin a sets both in band 12); main rail only.
// - Strap band 1.261 to 1.291 V selects 35 mV and 1.3 x on-time.
// - Aux temperature pin enables zero load-line on the agent rail.
// - Pin a bit 0 enables the overshoot guard; pin b bit 0 is only latched for status.
// - Guard turns low gate off when output reaches target (alert low).
// - While the guard is active both gates are masked.
// - The guard also acts on load-transient overshoot.
// - Pin c sixteen bands pick main and aux step thresholds.
// - Any over-current trip holds both switches off.
// - Summed threshold is 160 percent of the 0.4 V monitor current.
// - Summed trip latches after 40 us continuous excess.
// - Summed detection masked during a step and 80 us after.
// - Spike trip checks current during the first step, per max level.
// - Spike trip latches after 1 us above the spike threshold.
// - Step compensation window lasts 2 us from each step rise, one window for both rails.
module transient_and_overcurrent_guard #(
  parameter PHASES    = 2,
  parameter SENSE_W   = 12,
  parameter SUM_MASK  = `SUM_MASK_CYC
) (
  // Clock and reset
  input  wire               i_core_clk,
  input  wire               i_sys_rst,
  // AXI4-Lite write address and data
  input  wire               s_axi_awvalid,
  output wire               s_axi_awready,
  input  wire [3:0]         s_axi_awaddr,
  input  wire               s_axi_wvalid,
  output wire               s_axi_wready,
  input  wire [31:0]        s_axi_wdata,
  input  wire [3:0]         s_axi_wstrb,
  // AXI4-Lite write response
  output reg                s_axi_bvalid,
  input  wire               s_axi_bready,
  output reg  [1:0]         s_axi_bresp,
  // AXI4-Lite read
  input  wire               s_axi_arvalid,
  output wire               s_axi_arready,
  input  wire [3:0]         s_axi_araddr,
  output reg                s_axi_rvalid,
  input  wire               s_axi_rready,
  output reg  [31:0]        s_axi_rdata,
  output reg  [1:0]         s_axi_rresp,
  // Strap bands (digitised pin voltages, one band per 100 mV)
  input  wire [3:0]         i_config_pin_a,
  input  wire [3:0]         i_config_pin_b,
  input  wire [3:0]         i_config_pin_c,
  input  wire               i_aux_temp_config_pin,
  // Sensing
  input  wire [SENSE_W-1:0] i_output_sense,
  input  wire [SENSE_W-1:0] i_target_level,
  input  wire               i_alert_n,
  input  wire [SENSE_W-1:0] i_current_monitor,
  input  wire [SENSE_W-1:0] i_monitor_04,
  input  wire [SENSE_W-1:0] i_spike_level,
  input  wire               i_dynamic_voltage_step,
  input  wire               i_on_time_tick,
  // Gate requests from the modulator
  input  wire [PHASES-1:0]  i_pwm_high,
  input  wire [PHASES-1:0]  i_pwm_low,
  // Gate outputs, decoded settings and step window
  output reg  [PHASES-1:0]  o_high_side_gate,
  output reg  [PHASES-1:0]  o_low_side_gate,
  output reg                o_zero_load_line_agent,
  output reg  [7:0]         o_dynamic_step_threshold_main,
  output reg  [7:0]         o_dynamic_step_threshold_aux,
  output reg                o_step_window
);
  reg        strap_done;
  reg  [3:0] band_a;
  reg  [3:0] band_b;
  reg        guard_en_main;
  reg        guard_en_aux;
  reg  [7:0] quick_response_threshold;
  reg  [7:0] quick_response_width;
  reg        qr_enable;
  reg        qr_armed;
  reg        qr_active;
  reg  [7:0] qr_ticks;
  reg        guard_active;
  reg        sum_trip;
  reg        spike_trip;
  reg        first_step_seen;
  reg        in_first_step;
  reg        step_d;
  reg [12:0] mask_cnt;
  reg  [7:0] win_cnt;
  reg        aw_hold;
  reg  [3:0] aw_addr;
  reg        w_hold;
  reg [31:0] w_data;
  reg  [3:0] w_strb;
  wire       sum_over;
  wire       sum_masked;
  wire       sum_done;
  wire       spike_done;
  wire       fault;
  wire [SENSE_W-1:0] drop;
  wire [SENSE_W+7:0] sum_limit;
  wire [SENSE_W+7:0] sum_scaled;
  // Sized copies of the control reset value and timing constants, window length less one
  localparam [31:0]  CTRL_RST = `CTRL_RST_VAL;
  localparam integer WIN_LEN  = `STEP_WIN_CYC - 1;
  localparam integer SUM_DLY  = `SUM_DELAY_CYC;
  localparam integer SPK_DLY  = `SPIKE_DELAY_CYC;

  // Strap sampling once after reset release, then frozen
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      strap_done                    <= 1'b0;
      band_a                        <= 4'h0;
      band_b                        <= 4'h0;
      guard_en_main                 <= 1'b0;
      guard_en_aux                  <= 1'b0;
      o_zero_load_line_agent        <= 1'b0;
      o_dynamic_step_threshold_main <= `STEP_TH_OFF;
      o_dynamic_step_threshold_aux  <= `STEP_TH_OFF;
    end else if (!strap_done) begin
      strap_done             <= 1'b1;
      band_a                 <= i_config_pin_a;
      band_b                 <= i_config_pin_b;
      guard_en_main          <= i_config_pin_a[0];
      guard_en_aux           <= i_config_pin_b[0];
      o_zero_load_line_agent <= i_aux_temp_config_pin;
      o_dynamic_step_threshold_main <=
        step_code(i_config_pin_c[3:2]);
      o_dynamic_step_threshold_aux  <=
        step_code(i_config_pin_c[1:0]);
    end
  end

  // Four-way step threshold code: 15, 30, 60, disabled
  function [7:0] step_code;
    input [1:0] sel;
    begin
      case (sel)
        2'd0:    step_code = `STEP_TH_15;
        2'd1:    step_code = `STEP_TH_30;
        2'd2:    step_code = `STEP_TH_60;
        default: step_code = `STEP_TH_OFF;
      endcase
    end
  endfunction

  // Quick-response threshold from the main-rail strap band, width from band b outside band 12
  always @* begin
    case (band_a)
      `QR_BAND_35MV: begin
        quick_response_threshold = `QUICK_RESPONSE_THRESHOLD_35MV;
        quick_response_width     = `QUICK_RESPONSE_WIDTH_X10;
      end
      default: begin
        quick_response_threshold = 8'd15 + {2'b00, band_a, 2'b00};
        quick_response_width     = 8'd10 + {4'h0, band_b};
      end
    endcase
  end

  // Output droop below target
  assign drop = (i_target_level > i_output_sense) ?
                (i_target_level - i_output_sense) : {SENSE_W{1'b0}};

  // Quick-response one-shot, width counted in tenths of on-time
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      qr_armed  <= 1'b1;
      qr_active <= 1'b0;
      qr_ticks  <= 8'h00;
    end else if (qr_active) begin
      if (i_on_time_tick) begin
        if (qr_ticks + 8'd1 >= quick_response_width) begin
          qr_active <= 1'b0;
        end
        qr_ticks <= qr_ticks + 8'd1;
      end
    end else if (qr_enable && qr_armed && strap_done &&
                 drop >= {{(SENSE_W-8){1'b0}},
                          quick_response_threshold}) begin
      qr_active <= 1'b1;
      qr_armed  <= 1'b0;
      qr_ticks  <= 8'h00;
    end else if (drop < {{(SENSE_W-8){1'b0}},
                         quick_response_threshold}) begin
      qr_armed <= 1'b1;
    end
  end

  // Overshoot guard on step-up arrival or load-release overshoot
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      guard_active <= 1'b0;
    end else begin
      guard_active <= guard_en_main &&
                      (!i_alert_n ||
                       (i_output_sense > i_target_level));
    end
  end

  // Step edge, first-step flag, mask and 2 us windows
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      step_d          <= 1'b0;
      first_step_seen <= 1'b0;
      in_first_step   <= 1'b0;
      mask_cnt        <= 13'h0000;
      win_cnt         <= 8'h00;
      o_step_window   <= 1'b0;
    end else begin
      step_d <= i_dynamic_voltage_step;
      if (i_dynamic_voltage_step && !step_d) begin
        in_first_step   <= !first_step_seen;
        first_step_seen <= 1'b1;
        win_cnt         <= WIN_LEN[7:0];
        o_step_window   <= 1'b1;
      end else if (win_cnt != 8'h00) begin
        win_cnt <= win_cnt - 8'h01;
      end else begin
        o_step_window <= 1'b0;
      end
      if (!i_dynamic_voltage_step && step_d) begin
        in_first_step <= 1'b0;
      end
      if (i_dynamic_voltage_step) begin
        mask_cnt <= SUM_MASK[12:0];
      end else if (mask_cnt != 13'h0000) begin
        mask_cnt <= mask_cnt - 13'h0001;
      end
    end
  end

  // Summed limit: 160 percent of the 0.4 V monitor point
  assign sum_limit  = i_monitor_04 * `SUM_OC_PCT;
  // Current times 100 keeps the percent compare exact
  assign sum_scaled = i_current_monitor * `SUM_OC_BASE;
  assign sum_masked = i_dynamic_voltage_step || (mask_cnt != 13'h0000);
  assign sum_over   = !sum_masked && (sum_scaled > sum_limit);

  // 40 us continuous-excess timer for the summed trip
  hold_timer #(.WIDTH(12)) u_sum_timer (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_cond     (sum_over),
    .i_len      (SUM_DLY[11:0]),
    .o_done     (sum_done)
  );

  // 1 us timer for the spike trip during the first step
  hold_timer #(.WIDTH(12)) u_spike_timer (
    .i_core_clk (i_core_clk),
    .i_sys_rst  (i_sys_rst),
    .i_cond     (in_first_step &&
                 (i_current_monitor > i_spike_level)),
    .i_len      (SPK_DLY[11:0]),
    .o_done     (spike_done)
  );

  // Latched faults clear only by reset
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      sum_trip   <= 1'b0;
      spike_trip <= 1'b0;
    end else begin
      if (sum_done) begin
        sum_trip <= 1'b1;
      end
      if (spike_done) begin
        spike_trip <= 1'b1;
      end
    end
  end

  assign fault = sum_trip || spike_trip;

  // Gate drive with fault, guard and quick-response priority
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      o_high_side_gate <= {PHASES{1'b0}};
      o_low_side_gate  <= {PHASES{1'b0}};
    end else if (fault) begin
      o_high_side_gate <= {PHASES{1'b0}};
      o_low_side_gate  <= {PHASES{1'b0}};
    end else if (guard_active) begin
      o_high_side_gate <= {PHASES{1'b0}};
      o_low_side_gate  <= {PHASES{1'b0}};
    end else if (qr_active) begin
      o_high_side_gate <= {PHASES{1'b1}};
      o_low_side_gate  <= {PHASES{1'b0}};
    end else begin
      o_high_side_gate <= i_pwm_high;
      o_low_side_gate  <= i_pwm_low & ~i_pwm_high;
    end
  end

  // AXI4-Lite write path: address and data held until both present
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= 4'h0;
      w_data       <= 32'h0000_0000;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'b00;
      qr_enable    <= CTRL_RST[`CTRL_QR_EN_BIT];
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (aw_hold && w_hold) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == `REG_CTRL) ? 2'b00 : 2'b10;
        if (aw_addr == `REG_CTRL && w_strb[0]) begin
          qr_enable <= w_data[`CTRL_QR_EN_BIT];
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  assign s_axi_arready = !s_axi_rvalid;
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case (s_axi_araddr)
        `REG_CTRL:   s_axi_rdata <= {30'h0, qr_enable, 1'b0};
        `REG_STATUS: s_axi_rdata <= {24'h0, guard_en_aux, guard_en_main,
                                     o_step_window, guard_active,
                                     qr_active, spike_trip, sum_trip,
                                     strap_done};
        `REG_STRAP:  s_axi_rdata <= {20'h0, i_config_pin_c, band_b, band_a};
        `REG_QR_CFG: s_axi_rdata <= {16'h0, quick_response_width,
                                     quick_response_threshold};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule // transient_and_overcurrent_guard

// ===== verification/guard_checker.sv
// Port-level assertions for the transient and over-current guard
`timescale 1ns/1ps
module guard_checker #(
  parameter PHASES   = 2,
  parameter SENSE_W  = 12,
  parameter SUM_MASK = 3200
) (
  // Clock and reset
  input wire               i_core_clk,
  input wire               i_sys_rst,
  // Straps and sensing
  input wire [3:0]         i_config_pin_a,
  input wire [3:0]         i_config_pin_c,
  input wire               i_aux_temp_config_pin,
  input wire [SENSE_W-1:0] i_output_sense,
  input wire [SENSE_W-1:0] i_target_level,
  input wire               i_alert_n,
  input wire [SENSE_W-1:0] i_current_monitor,
  input wire [SENSE_W-1:0] i_monitor_04,
  input wire [SENSE_W-1:0] i_spike_level,
  input wire               i_dynamic_voltage_step,
  // Gates and decoded settings
  input wire [PHASES-1:0]  i_pwm_high,
  input wire [PHASES-1:0]  i_pwm_low,
  input wire [PHASES-1:0]  o_high_side_gate,
  input wire [PHASES-1:0]  o_low_side_gate,
  input wire               o_zero_load_line_agent,
  input wire [7:0]         o_dynamic_step_threshold_main,
  input wire [7:0]         o_dynamic_step_threshold_aux,
  input wire               o_step_window
);
  reg  [1:0]  up;
  reg  [7:0]  win, calm;
  reg  [11:0] mcnt, scnt;
  reg         ga, hot, trip;
  wire        ovr = i_current_monitor * 20'h0_000A > i_monitor_04 * 20'h0_0010;
  wire        msk = i_dynamic_voltage_step || mcnt != 12'h000;
  wire        gz  = o_high_side_gate == 0 && o_low_side_gate == 0;
  // Two-bit band field to step threshold in mV
  function [7:0] thr(input [1:0] f);
    thr = f == 2'h0 ? 8'h0F : f == 2'h1 ? 8'h1E : f == 2'h2 ? 8'h3C : 8'h00;
  endfunction
  // Age, window length, quiet time and unmasked excess count
  always @(posedge i_core_clk) begin
    if (i_sys_rst) begin
      up   <= 2'h0;
      win  <= 8'h00;
      calm <= 8'h00;
      mcnt <= 12'h000;
      scnt <= 12'h000;
      ga   <= 1'b0;
      hot  <= 1'b0;
      trip <= 1'b0;
    end else begin
      if (up != 2'h3) up <= up + 2'h1;
      if (up == 2'h0) ga <= i_config_pin_a[0];
      win <= o_step_window ? win + 8'h01 : 8'h00;
      if (i_target_level != i_output_sense || (ga && !i_alert_n)) calm <= 8'h00;
      else if (calm != 8'hFF) calm <= calm + 8'h01;
      if (i_dynamic_voltage_step) mcnt <= SUM_MASK[11:0];
      else if (mcnt != 12'h000) mcnt <= mcnt - 12'h001;
      scnt <= (ovr && !msk) ? scnt + 12'h001 : 12'h000;
      if (ovr || i_current_monitor > i_spike_level) hot <= 1'b1;
      if (scnt == 12'h64A) trip <= 1'b1;
    end
  end
  default clocking cb @(posedge i_core_clk);
  endclocking
  default disable iff (i_sys_rst);
  a_main_step: assert property (
    up == 2'h3 |-> o_dynamic_step_threshold_main == thr(i_config_pin_c[3:2]))
    else $error("main step threshold wrong");
  a_aux_step: assert property (
    up == 2'h3 |-> o_dynamic_step_threshold_aux == thr(i_config_pin_c[1:0]))
    else $error("aux step threshold wrong");
  a_zero_line: assert property (
    up == 2'h3 |-> o_zero_load_line_agent == i_aux_temp_config_pin)
    else $error("zero load-line select wrong");
  a_window_start: assert property (
    $rose(i_dynamic_voltage_step) |-> ##[1:2] o_step_window)
    else $error("step window did not open");
  a_window_len: assert property (
    $fell(o_step_window) |-> win == 8'h50)
    else $error("step window length wrong");
  a_guard_mask: assert property (
    up == 2'h3 && ga && !i_alert_n |-> ##2 gz)
    else $error("guard did not mask gates");
  a_gate_pass: assert property (
    up == 2'h3 && calm > 8'h63 && !hot |=> o_high_side_gate ==
    $past(i_pwm_high) && o_low_side_gate == $past(i_pwm_low))
    else $error("gates do not follow modulator");
  a_trip_hold: assert property (
    trip |-> gz)
    else $error("gates on after summed trip");
  c_window: cover property ($rose(o_step_window));
  c_trip: cover property (trip);
  c_guard: cover property (up == 2'h3 && ga && !i_alert_n);
  c_pulse: cover property (o_high_side_gate != 0 && i_pwm_high == 0);
endmodule // guard_checker

bind transient_and_overcurrent_guard guard_checker #(
  .PHASES(PHASES), .SENSE_W(SENSE_W), .SUM_MASK(SUM_MASK)
) guard_checker_i (.*);

// ===== verification/power_stage_model.sv
// Behavioural power stage and output sensing network
`timescale 1ns/1ps
module power_stage_model #(
  parameter SENSE_W = 12
) (
  // Clock
  input  wire               i_core_clk,
  // Load and droop set by the bench
  input  wire [SENSE_W-1:0] i_load,
  input  wire [SENSE_W-1:0] i_target_level,
  input  wire [SENSE_W-1:0] i_droop,
  // Sensed values back to the block
  output reg  [SENSE_W-1:0] o_output_sense,
  output reg  [SENSE_W-1:0] o_current_monitor
);
  initial begin
    o_output_sense    = 0;
    o_current_monitor = 0;
  end
  // Sense filters lag the load by one cycle
  always @(posedge i_core_clk) begin
    o_current_monitor <= i_load;
    o_output_sense    <= i_target_level - i_droop;
  end
endmodule // power_stage_model

// ===== verification/tb_transient_and_overcurrent_guard.sv
// Directed bench for the transient and over-current guard
`timescale 1ns/1ps
module tb_transient_and_overcurrent_guard;
  reg         i_core_clk, i_sys_rst, s_axi_awvalid, s_axi_wvalid;
  reg         s_axi_bready, s_axi_arvalid, s_axi_rready;
  reg  [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  reg  [31:0] s_axi_wdata;
  wire        s_axi_awready, s_axi_wready, s_axi_bvalid;
  wire        s_axi_arready, s_axi_rvalid;
  wire [1:0]  s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  reg  [3:0]  i_config_pin_a, i_config_pin_b, i_config_pin_c;
  reg         i_aux_temp_config_pin, i_alert_n, i_on_time_tick;
  reg         i_dynamic_voltage_step;
  reg  [11:0] i_target_level, i_monitor_04, i_spike_level, load, droop;
  wire [11:0] i_output_sense, i_current_monitor;
  reg  [1:0]  i_pwm_high, i_pwm_low, tc;
  wire [1:0]  o_high_side_gate, o_low_side_gate;
  wire        o_zero_load_line_agent, o_step_window;
  wire [7:0]  o_dynamic_step_threshold_main, o_dynamic_step_threshold_aux;
  integer     mismatches, checks, k, n, c;
  transient_and_overcurrent_guard #(.SUM_MASK(20))
    transient_and_overcurrent_guard_i (.*);
  power_stage_model power_stage_model_i (
    .i_core_clk       (i_core_clk),
    .i_load           (load),
    .i_target_level   (i_target_level),
    .i_droop          (droop),
    .o_output_sense   (i_output_sense),
    .o_current_monitor(i_current_monitor)
  );
  // Clock and a tick every fourth cycle
  always #12.5 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    tc <= tc + 2'h1;
    i_on_time_tick <= tc == 2'h3;
  end
  function [31:0] thr(input [1:0] f);
    thr = f == 2'h0 ? 15 : f == 2'h1 ? 30 : f == 2'h2 ? 60 : 0;
  endfunction
  task summarize;
    begin
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
    begin
      checks = checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
      end
    end
  endtask
  task cyc(input integer m);
    begin
      repeat (m) @(posedge i_core_clk);
      #1;
    end
  endtask
  // One AXI4-Lite access; a read compares masked data
  task bus(input w, input [3:0] a, input [31:0] d, input [31:0] m,
           input [1:0] er);
    reg taw, tw, ta, tb;
    begin
      s_axi_awaddr  <= a;
      s_axi_araddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= w;
      s_axi_wvalid  <= w;
      s_axi_bready  <= w;
      s_axi_arvalid <= !w;
      s_axi_rready  <= !w;
      tb = 1'b0;
      n = 0;
      while (!tb) begin
        @(negedge i_core_clk);
        taw = s_axi_awvalid && s_axi_awready;
        tw = s_axi_wvalid && s_axi_wready;
        ta = s_axi_arvalid && s_axi_arready;
        tb = w ? s_axi_bvalid === 1'b1 : s_axi_rvalid === 1'b1;
        if (tb) chk(w ? s_axi_bresp : s_axi_rresp, er);
        if (tb && !w) chk(s_axi_rdata & m, d);
        @(posedge i_core_clk);
        if (taw) s_axi_awvalid <= 1'b0;
        if (tw) s_axi_wvalid <= 1'b0;
        if (ta) s_axi_arvalid <= 1'b0;
        n = n + 1;
        if (n > 200) begin
          mismatches = mismatches + 1;
          summarize;
        end
      end
      s_axi_bready <= 1'b0;
      s_axi_rready <= 1'b0;
      #1;
    end
  endtask
  task boot(input [3:0] a, input [3:0] cc);
    begin
      i_config_pin_a <= a;
      i_config_pin_c <= cc;
      i_aux_temp_config_pin <= cc[0];
      i_sys_rst <= 1'b1;
      cyc(4);
      i_sys_rst <= 1'b0;
      cyc(4);
    end
  endtask
  // Count cycles until the high gates show a value
  task hw(input [1:0] e, input integer lim);
    begin
      c = 0;
      while (o_high_side_gate !== e && c < lim) begin
        cyc(1);
        c = c + 1;
      end
    end
  endtask
  initial begin
    {i_core_clk, i_sys_rst, s_axi_awvalid, s_axi_wvalid} = 4'h0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, i_on_time_tick} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, tc} = 0;
    {i_config_pin_a, i_config_pin_b, i_config_pin_c} = 0;
    {i_aux_temp_config_pin, i_dynamic_voltage_step} = 2'h0;
    {i_pwm_high, i_pwm_low, load, droop} = 0;
    s_axi_wstrb = 4'hF;
    i_alert_n = 1'b1;
    i_target_level = 12'h320;
    i_monitor_04 = 12'h064;
    i_spike_level = 12'hFFF;
    mismatches = 0;
    checks = 0;
    for (k = 0; k < 16; k = k + 1) begin
      boot(k[3:0], k[3:0]);
      chk(o_dynamic_step_threshold_main, thr(k[3:2]));
      chk(o_dynamic_step_threshold_aux, thr(k[1:0]));
      chk(o_zero_load_line_agent, k[0]);
      if (k == 12) bus(0, 4'hC, 32'h0000_0D23, 32'h0000_FFFF, 2'h0);
      i_pwm_high <= 2'b10;
      i_pwm_low <= 2'b01;
      i_alert_n <= 1'b0;
      cyc(2);
      chk(o_high_side_gate, k[0] ? 2'b00 : 2'b10);
      chk(o_low_side_gate, k[0] ? 2'b00 : 2'b01);
      i_alert_n <= 1'b1;
      cyc(1);
    end
    i_config_pin_a <= 4'h0;
    i_alert_n <= 1'b0;
    cyc(3);
    chk(o_high_side_gate, 2'b00);
    bus(0, 4'h8, 32'h0000_0F0F, 32'h0000_0FFF, 2'h0);
    bus(0, 4'h4, 32'h0000_0040, 32'h0000_00C0, 2'h0);
    $display("strap test done");
    i_alert_n <= 1'b1;
    i_pwm_high <= 2'b00;
    i_pwm_low <= 2'b00;
    boot(4'hC, 4'h0);
    bus(0, 4'h0, 32'h0000_0002, 32'hFFFF_FFFF, 2'h0);
    droop <= 12'h01E;
    cyc(20);
    chk(o_high_side_gate, 2'b00);
    droop <= 12'h028;
    hw(2'b11, 10);
    chk(c < 10, 1);
    hw(2'b00, 100);
    chk(c > 44 && c < 60, 1);
    droop <= 12'h000;
    bus(1, 4'h0, 32'h0000_0000, 0, 2'h0);
    bus(1, 4'h4, 32'h0000_0000, 0, 2'h2);
    bus(0, 4'h0, 32'h0000_0000, 32'hFFFF_FFFF, 2'h0);
    droop <= 12'h028;
    cyc(20);
    chk(o_high_side_gate, 2'b00);
    droop <= 12'h000;
    $display("quick response test done");
    boot(4'h0, 4'h0);
    i_pwm_high <= 2'b11;
    load <= 12'h0A0;
    cyc(1700);
    chk(o_high_side_gate, 2'b11);
    load <= 12'h0A1;
    cyc(1500);
    load <= 12'h000;
    cyc(2);
    load <= 12'h0A1;
    cyc(1590);
    chk(o_high_side_gate, 2'b11);
    cyc(30);
    chk({o_high_side_gate, o_low_side_gate}, 4'h0);
    load <= 12'h000;
    cyc(50);
    chk(o_high_side_gate, 2'b00);
    bus(0, 4'h4, 32'h0000_0002, 32'h0000_0002, 2'h0);
    $display("summed trip test done");
    boot(4'h0, 4'h0);
    i_dynamic_voltage_step <= 1'b1;
    load <= 12'h0A1;
    cyc(40);
    chk(o_step_window, 1);
    cyc(60);
    chk(o_step_window, 0);
    i_dynamic_voltage_step <= 1'b0;
    cyc(1605);
    chk(o_high_side_gate, 2'b11);
    cyc(40);
    chk(o_high_side_gate, 2'b00);
    load <= 12'h000;
    $display("mask test done");
    boot(4'h0, 4'h0);
    i_spike_level <= 12'h0C8;
    load <= 12'h0C9;
    cyc(100);
    chk(o_high_side_gate, 2'b11);
    i_dynamic_voltage_step <= 1'b1;
    cyc(30);
    chk(o_high_side_gate, 2'b11);
    cyc(20);
    chk(o_high_side_gate, 2'b00);
    i_dynamic_voltage_step <= 1'b0;
    load <= 12'h000;
    bus(0, 4'h4, 32'h0000_0004, 32'h0000_0004, 2'h0);
    boot(4'h0, 4'h0);
    i_dynamic_voltage_step <= 1'b1;
    cyc(10);
    i_dynamic_voltage_step <= 1'b0;
    cyc(100);
    load <= 12'h0C9;
    i_dynamic_voltage_step <= 1'b1;
    cyc(100);
    chk(o_high_side_gate, 2'b11);
    i_dynamic_voltage_step <= 1'b0;
    load <= 12'h000;
    $display("spike trip test done");
    summarize;
  end
endmodule // tb_transient_and_overcurrent_guard
